// file: hdl/afu_flag_update.v
`timescale 1ns/1ps
`include "afu_defs.vh"
// Operation
// - Add/sub forms write all four flags
// - Memory inc/dec write all four flags
// - And/or/xor write only zero
// - Invert and negate write only zero
// - Loads from memory/IO set zero only
// - Shifts write only carry
// - Bit-carry swap writes only carry
// - Compare-skip ops write all flags like subtract
// - Inc/dec-skip-zero write all four flags
// - Flag restore overwrites all four flags
// - Moves, bit ops, jumps, system ops keep flags
// - Bit access only at RAM 0x00..0x3f
module afu_flag_update (
    // Clock and reset
    input  wire        sys_clk_i,
    input  wire        sys_rst_i,
    // Avalon-MM slave
    input  wire [3:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    // Sequencer side
    input  wire        exec_i,
    input  wire [4:0]  op_i,
    input  wire [7:0]  opa_i,
    input  wire [7:0]  opb_i,
    input  wire        bit_req_i,
    input  wire [7:0]  bit_addr_i,
    // Flag and result outputs
    output reg  [3:0]  flags_o,
    output reg  [7:0]  result_o,
    output reg         bit_ok_o
);

    // Register state
    // Port copies are separate flops so outputs leave straight from registers
    reg  [3:0]  flags_reg;     // Z C AC OV
    reg  [3:0]  flags_next;
    reg  [7:0]  result_reg;    // Last operation result
    reg  [7:0]  result_next;
    reg  [4:0]  sw_op_reg;     // Software-issued operation
    reg  [7:0]  sw_a_reg;      // Software operand a
    reg  [7:0]  sw_b_reg;      // Software operand b
    reg         sw_go_reg;     // One-cycle software execute
    reg         ack_reg;       // Bus answer pending
    reg         bit_ok_reg;    // Last bit-address verdict

    // Selected operation: sequencer has priority over software
    // Limitation: a software op that meets a sequencer op is lost
    // Sequencer ops are taken in the cycle that exec_i is high
    wire        go    = exec_i | sw_go_reg;
    wire [4:0]  op    = exec_i ? op_i : sw_op_reg;
    wire [7:0]  a     = exec_i ? opa_i : sw_a_reg;
    wire [7:0]  b     = exec_i ? opb_i : sw_b_reg;
    wire        cin   = flags_reg[`AFU_FLAG_C];

    // Adder control
    // One adder serves add, subtract, compare, inc and dec
    reg  [7:0]  ar_b;
    reg         ar_cin;
    reg         ar_sub;
    wire [7:0]  ar_sum;
    wire        ar_c;
    wire        ar_ac;
    wire        ar_ov;
    wire        bit_ok;

    // Logic unit result, shared by and, or and xor
    reg  [7:0]  logic_res;

    // Swap-carry byte: the addressed lane takes the old carry
    wire [7:0]  swap_sel = 8'h01 << b[2:0];   // One-hot lane select
    wire [7:0]  swap_res;                     // Byte after the exchange
    genvar      gi;

    // Decode helper: is this op a full arithmetic update
    // Compare shares the subtract path but stores no result
    function is_arith;
        input [4:0] o;
        begin
            case (o)
                `AFU_OP_ADD, `AFU_OP_ADDC, `AFU_OP_SUB, `AFU_OP_SUBC,
                `AFU_OP_INC, `AFU_OP_DEC, `AFU_OP_CMP: is_arith = 1'b1;
                default: is_arith = 1'b0;
            endcase
        end
    endfunction

    // Zero test shared by every Z update except invert, which compares with 8'hff, and flag restore, which takes b[0]
    function is_zero;
        input [7:0] v;
        begin
            is_zero = (v == 8'h00);
        end
    endfunction

    // Each lane decides alone, so no variable bit index is needed
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_swap
            assign swap_res[gi] = swap_sel[gi] ? cin : a[gi];
        end
    endgenerate

    // Logic unit: one mux in place of three copies of each operator
    always @* begin
        case (op)
            `AFU_OP_AND: logic_res = a & b;
            `AFU_OP_OR:  logic_res = a | b;
            default:     logic_res = a ^ b;
        endcase
    end

    // Shared adder
    // Carry and AC come back as borrow when subtracting
    afu_arith u_arith (
        .a_i   (a),
        .b_i   (ar_b),
        .cin_i (ar_cin),
        .sub_i (ar_sub),
        .sum_o (ar_sum),
        .c_o   (ar_c),
        .ac_o  (ar_ac),
        .ov_o  (ar_ov)
    );

    // Bit-address range check
    // Decoding never reaches RAM above the bit-addressable range
    afu_bitchk u_bitchk (
        .addr_i (bit_addr_i),
        .ok_o   (bit_ok)
    );

    // Adder operand selection
    // Defaults give a plain add with no carry in
    always @* begin
        ar_b   = b;
        ar_cin = 1'b0;
        ar_sub = 1'b0;
        case (op)
            `AFU_OP_ADDC: begin
                ar_cin = cin;
            end
            `AFU_OP_SUB, `AFU_OP_CMP: begin
                ar_sub = 1'b1;
            end
            `AFU_OP_SUBC: begin
                ar_sub = 1'b1;
                ar_cin = cin;                  // Borrow in
            end
            `AFU_OP_INC: begin
                ar_b = 8'h01;
            end
            `AFU_OP_DEC: begin
                ar_b   = 8'h01;
                ar_sub = 1'b1;
            end
            default: begin
                ar_b = b;
            end
        endcase
    end

    // Flag and result next-state
    // Default is hold, so an op not named below keeps every flag
    always @* begin
        flags_next  = flags_reg;
        result_next = result_reg;
        if (go) begin
            if (is_arith(op)) begin
                // Full update from adder
                // Only this class and flag restore touch carry, AC and OV together
                flags_next[`AFU_FLAG_Z]  = is_zero(ar_sum);
                flags_next[`AFU_FLAG_C]  = ar_c;
                flags_next[`AFU_FLAG_AC] = ar_ac;
                flags_next[`AFU_FLAG_OV] = ar_ov;
                // Compare keeps no result byte
                if (op != `AFU_OP_CMP) begin
                    result_next = ar_sum;
                end
            end else begin
                case (op)
                    `AFU_OP_AND: begin
                        result_next = logic_res;
                        flags_next[`AFU_FLAG_Z] = is_zero(logic_res);
                    end
                    `AFU_OP_OR: begin
                        result_next = logic_res;
                        flags_next[`AFU_FLAG_Z] = is_zero(logic_res);
                    end
                    `AFU_OP_XOR: begin
                        result_next = logic_res;
                        flags_next[`AFU_FLAG_Z] = is_zero(logic_res);
                    end
                    `AFU_OP_NOT: begin
                        result_next = ~a;
                        flags_next[`AFU_FLAG_Z] = (a == 8'hff);
                    end
                    `AFU_OP_NEG: begin
                        // Negate gives zero only from a zero operand
                        result_next = 8'h00 - a;
                        flags_next[`AFU_FLAG_Z] = is_zero(a);
                    end
                    `AFU_OP_LOAD: begin
                        // Memory or IO load into accumulator
                        result_next = a;
                        flags_next[`AFU_FLAG_Z] = is_zero(a);
                    end
                    `AFU_OP_SHR: begin
                        result_next = {1'b0, a[7:1]};
                        flags_next[`AFU_FLAG_C] = a[0];
                    end
                    `AFU_OP_SHRC: begin
                        // Old carry enters the top bit
                        result_next = {cin, a[7:1]};
                        flags_next[`AFU_FLAG_C] = a[0];
                    end
                    `AFU_OP_SHL: begin
                        result_next = {a[6:0], 1'b0};
                        flags_next[`AFU_FLAG_C] = a[7];
                    end
                    `AFU_OP_SHLC: begin
                        // Old carry enters bit 0
                        result_next = {a[6:0], cin};
                        flags_next[`AFU_FLAG_C] = a[7];
                    end
                    `AFU_OP_SWAPC: begin
                        // b[2:0] picks the IO bit exchanged with carry
                        result_next = swap_res;
                        flags_next[`AFU_FLAG_C] = a[b[2:0]];
                    end
                    `AFU_OP_POPF: begin
                        // Popped flag nibble arrives in b[3:0]
                        // All four bits come from the stack image
                        result_next = a;
                        flags_next  = b[3:0];
                    end
                    default: begin
                        // Moves, bit ops, flow and system ops
                        // Unused op codes fall here as well
                        flags_next  = flags_reg;
                        result_next = result_reg;
                    end
                endcase
            end
        end
    end

    // Datapath registers
    // Flags and result clear to zero with the chip
    always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags_reg  <= `AFU_FLAGS_RST;
            result_reg <= 8'h00;
            bit_ok_reg <= 1'b0;
        end else begin
            flags_reg  <= flags_next;
            result_reg <= result_next;
            // Verdict for sequencer bit access
            // Verdict holds between requests for a late reader
            if (bit_req_i) begin
                bit_ok_reg <= bit_ok;
            end
        end
    end

    // Avalon slave: one wait cycle then answer
    // Trade-off: a wait state on every access keeps the decode registered
    // The cycle after an answer is dead, so a held request is taken once
    always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            // Bus idles with waitrequest high
            ack_reg           <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h0000_0000;
            sw_op_reg         <= `AFU_OP_NONE;
            sw_a_reg          <= 8'h00;
            sw_b_reg          <= 8'h00;
            sw_go_reg         <= 1'b0;
        end else begin
            sw_go_reg         <= 1'b0;
            avs_waitrequest_o <= 1'b1;
            if ((avs_read_i || avs_write_i) && !ack_reg) begin
                ack_reg           <= 1'b1;
                avs_waitrequest_o <= 1'b0;
                if (avs_write_i) begin
                    case (avs_address_i)
                        `AFU_OFF_CTRL: begin
                            // Writing low byte issues an operation
                            if (avs_byteenable_i[0]) begin
                                sw_op_reg <= avs_writedata_i[4:0];
                                sw_go_reg <= 1'b1;
                            end
                        end
                        `AFU_OFF_OPND: begin
                            // Lane 0 is operand a, lane 1 operand b
                            if (avs_byteenable_i[0]) begin
                                sw_a_reg <= avs_writedata_i[7:0];
                            end
                            if (avs_byteenable_i[1]) begin
                                sw_b_reg <= avs_writedata_i[15:8];
                            end
                        end
                        default: begin
                            // Read-only or unmapped: write ignored
                            sw_go_reg <= 1'b0;
                        end
                    endcase
                end else begin
                    // Read data stands from the answer until the next read
                    case (avs_address_i)
                        `AFU_OFF_CTRL:   avs_readdata_o <= {27'h0, sw_op_reg};
                        `AFU_OFF_OPND:   avs_readdata_o <= {16'h0, sw_b_reg, sw_a_reg};
                        `AFU_OFF_FLAGS:  avs_readdata_o <= {28'h0, flags_reg};
                        `AFU_OFF_RESULT: avs_readdata_o <= {24'h0, result_reg};
                        default:         avs_readdata_o <= 32'h0000_0000;
                    endcase
                end
            end else begin
                ack_reg <= 1'b0;
            end
        end
    end

    // Registered top outputs
    // Ports take the same next state as the internal copies
    always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags_o  <= `AFU_FLAGS_RST;
            result_o <= 8'h00;
            bit_ok_o <= 1'b0;
        end else begin
            flags_o  <= flags_next;
            result_o <= result_next;
            // Bit verdict follows a new request at once, else holds
            bit_ok_o <= bit_req_i ? bit_ok : bit_ok_reg;
        end
    end

endmodule // afu_flag_update

// file: hdl/afu_defs.vh
`ifndef AFU_DEFS_VH
`define AFU_DEFS_VH

// Avalon register byte offsets
`define AFU_OFF_CTRL      4'h0
`define AFU_OFF_OPND      4'h4
`define AFU_OFF_FLAGS     4'h8
`define AFU_OFF_RESULT    4'hc

// Flag bit positions
`define AFU_FLAG_Z        0
`define AFU_FLAG_C        1
`define AFU_FLAG_AC       2
`define AFU_FLAG_OV       3

// Operation class codes
`define AFU_OP_NONE       5'h00
`define AFU_OP_ADD        5'h01
`define AFU_OP_ADDC       5'h02
`define AFU_OP_SUB        5'h03
`define AFU_OP_SUBC       5'h04
`define AFU_OP_INC        5'h05
`define AFU_OP_DEC        5'h06
`define AFU_OP_AND        5'h07
`define AFU_OP_OR         5'h08
`define AFU_OP_XOR        5'h09
`define AFU_OP_NOT        5'h0a
`define AFU_OP_NEG        5'h0b
`define AFU_OP_LOAD       5'h0c
`define AFU_OP_SHR        5'h0d
`define AFU_OP_SHRC       5'h0e
`define AFU_OP_SHL        5'h0f
`define AFU_OP_SHLC       5'h10
`define AFU_OP_SWAPC      5'h11
`define AFU_OP_CMP        5'h12
`define AFU_OP_POPF       5'h13

// Bit-addressable RAM limit
`define AFU_BIT_RAM_MAX   8'h3f

// Reset values
`define AFU_FLAGS_RST     4'h0

`endif

// file: hdl/afu_arith.v
`timescale 1ns/1ps
// Combinational 8-bit arithmetic with nibble carry and signed overflow
module afu_arith (
    // Operands
    input  wire [7:0] a_i,
    input  wire [7:0] b_i,
    input  wire       cin_i,
    input  wire       sub_i,
    // Results
    output wire [7:0] sum_o,
    output wire       c_o,
    output wire       ac_o,
    output wire       ov_o
);
    wire [7:0] b_eff;   // Inverted for subtract
    wire       c_eff;   // Carry-in after inversion
    wire [4:0] low;     // Low nibble sum
    wire [8:0] full;    // Full sum

    assign b_eff = sub_i ? ~b_i : b_i;
    // Subtract is a + ~b + 1 - borrow
    assign c_eff = sub_i ? ~cin_i : cin_i;
    assign low   = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, c_eff};
    assign full  = {1'b0, a_i} + {1'b0, b_eff} + {8'h00, c_eff};
    assign sum_o = full[7:0];
    // Borrow is the inverted carry when subtracting
    assign c_o   = sub_i ? ~full[8] : full[8];
    assign ac_o  = sub_i ? ~low[4] : low[4];
    assign ov_o  = (a_i[7] == b_eff[7]) && (full[7] != a_i[7]);
endmodule // afu_arith

// file: hdl/afu_bitchk.v
`timescale 1ns/1ps
`include "afu_defs.vh"
// Checks whether a RAM byte address may take single-bit access
module afu_bitchk (
    // Address in
    input  wire [7:0] addr_i,
    // Verdict out
    output wire       ok_o
);
    // Only the lowest 64 bytes decode for bit operations
    assign ok_o = (addr_i <= `AFU_BIT_RAM_MAX);
endmodule // afu_bitchk

// file: testbench/afu_flag_update_checker.sv
`timescale 1ns/1ps
`include "afu_defs.vh"
module afu_flag_update_checker (
    // Clock and reset
    input wire        sys_clk_i,
    input wire        sys_rst_i,
    // Bus handshake
    input wire        avs_read_i,
    input wire        avs_write_i,
    input wire        avs_waitrequest_o,
    // Sequencer side and block outputs
    input wire        exec_i,
    input wire [4:0]  op_i,
    input wire [7:0]  opa_i,
    input wire [7:0]  opb_i,
    input wire        bit_req_i,
    input wire [7:0]  bit_addr_i,
    input wire [3:0]  flags_o,
    input wire [7:0]  result_o,
    input wire        bit_ok_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Ops that may touch only zero, and ops that may touch only carry
    wire z_op = exec_i && op_i >= `AFU_OP_AND && op_i <= `AFU_OP_LOAD;
    wire c_op = exec_i && op_i >= `AFU_OP_SHR && op_i <= `AFU_OP_SWAPC;
    wire shr  = exec_i && (op_i == `AFU_OP_SHR || op_i == `AFU_OP_SHRC);
    wire none = exec_i && (op_i == `AFU_OP_NONE || op_i > `AFU_OP_POPF);
    chk_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o) else $error("bus request left unanswered");
    chk_bus_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("answer lasted more than one cycle");
    chk_zero_only: assert property (z_op |=> (flags_o & 4'he) == ($past(flags_o) & 4'he))
        else $error("logic op changed a non-zero flag");
    chk_carry_only: assert property (c_op |=> (flags_o & 4'hd) == ($past(flags_o) & 4'hd))
        else $error("shift changed a non-carry flag");
    chk_shr_carry: assert property (shr |=> flags_o[1] == |($past(opa_i) & 8'h01))
        else $error("right shift carry wrong");
    chk_keep_all: assert property (none |=> flags_o == $past(flags_o))
        else $error("no-flag op changed flags");
    chk_pop_flags: assert property (exec_i && op_i == `AFU_OP_POPF
        |=> {4'h0, flags_o} == ($past(opb_i) & 8'h0f)) else $error("flag restore wrong");
    chk_add_zero: assert property (exec_i && op_i == `AFU_OP_ADD
        |=> result_o == $past(opa_i) + $past(opb_i) && flags_o[0] == (result_o == 8'h00))
        else $error("add result or zero wrong");
    chk_bit_range: assert property (bit_req_i |=> bit_ok_o == ($past(bit_addr_i) <= 8'h3f))
        else $error("bit access range wrong");
endmodule // afu_flag_update_checker

bind afu_flag_update afu_flag_update_checker chk_u (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o), .exec_i(exec_i), .op_i(op_i), .opa_i(opa_i),
    .opb_i(opb_i), .bit_req_i(bit_req_i), .bit_addr_i(bit_addr_i), .flags_o(flags_o),
    .result_o(result_o), .bit_ok_o(bit_ok_o));

// file: testbench/afu_seq_model.sv
`timescale 1ns/1ps
// Sequencer stand-in; idle operands toggle so stale values never look valid
module afu_seq_model (
    // Clock
    input  wire       sys_clk_i,
    // Operation request towards the block
    output reg        exec_o,
    output reg  [4:0] op_o,
    output reg  [7:0] opa_o,
    output reg  [7:0] opb_o,
    output reg        bit_req_o,
    output reg  [7:0] bit_addr_o
);
    reg        go_reg;   // Op due at next edge
    reg [28:0] pend_reg; // Op, a, b, bit address
    initial begin
        go_reg = 1'b0;
        pend_reg = 29'h0;
        {exec_o, op_o, opa_o, opb_o, bit_req_o, bit_addr_o} = 31'h0;
    end
    // One process drives every output, so no double assignment per edge
    always @(posedge sys_clk_i) begin
        exec_o <= go_reg;
        bit_req_o <= go_reg;
        if (go_reg) begin
            {op_o, opa_o, opb_o, bit_addr_o} <= pend_reg;
        end else begin
            {op_o, opa_o, opb_o, bit_addr_o} <= ~{op_o, opa_o, opb_o, bit_addr_o};
        end
    end
    // Returns at the edge that executes the op
    task issue(input [4:0] op, input [7:0] a, input [7:0] b, input [7:0] ad);
        begin
            pend_reg <= {op, a, b, ad};
            go_reg <= 1'b1;
            @(posedge sys_clk_i);
            go_reg <= 1'b0;
            @(posedge sys_clk_i);
        end
    endtask
endmodule // afu_seq_model

// file: testbench/tb.sv
`timescale 1ns/1ps
`include "afu_defs.vh"
module tb;
    reg         sys_clk_i = 1'b0;
    reg         sys_rst_i = 1'b1;
    reg  [3:0]  avs_address_i = 4'h0;
    reg         avs_read_i = 1'b0;
    reg         avs_write_i = 1'b0;
    reg  [31:0] avs_writedata_i = 32'h0;
    wire [31:0] avs_readdata_o;
    wire        avs_waitrequest_o, exec_w, bit_req_w, bit_ok_o;
    wire [4:0]  op_w;
    wire [7:0]  opa_w, opb_w, bit_addr_w, result_o;
    wire [3:0]  flags_o;
    integer     n_mismatch = 0, total_checks = 0, i;
    reg  [31:0] rng = 32'hef5c19d4, rd;
    reg  [3:0]  ef = 4'h0; // Expected flags
    reg  [7:0]  er = 8'h0; // Expected result
    reg  [12:0] e;
    always #12.5 sys_clk_i = ~sys_clk_i;
    afu_seq_model seq_u (.sys_clk_i(sys_clk_i), .exec_o(exec_w), .op_o(op_w), .opa_o(opa_w),
        .opb_o(opb_w), .bit_req_o(bit_req_w), .bit_addr_o(bit_addr_w));
    afu_flag_update dut_u (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .exec_i(exec_w), .op_i(op_w), .opa_i(opa_w), .opb_i(opb_w), .bit_req_i(bit_req_w),
        .bit_addr_i(bit_addr_w), .flags_o(flags_o), .result_o(result_o), .bit_ok_o(bit_ok_o));
    // Reference: {has result, result, {OV,AC,C,Z}}
    function [12:0] ref_op(input [4:0] op, input [7:0] a, input [7:0] b, input [3:0] f);
        reg [8:0] s;
        reg [4:0] n;
        reg [7:0] bb, r;
        reg       ci, sb;
        reg [3:0] o;
        begin
            o = f;
            bb = (op == `AFU_OP_INC || op == `AFU_OP_DEC) ? 8'h01 : b;
            ci = (op == `AFU_OP_ADDC || op == `AFU_OP_SUBC) ? f[`AFU_FLAG_C] : 1'b0;
            sb = op == `AFU_OP_SUB || op == `AFU_OP_SUBC || op == `AFU_OP_DEC || op == `AFU_OP_CMP;
            s = sb ? {1'b0, a} - bb - ci : {1'b0, a} + bb + ci;
            n = sb ? {1'b0, a[3:0]} - bb[3:0] - ci : {1'b0, a[3:0]} + bb[3:0] + ci;
            r = (op == `AFU_OP_AND) ? a & b : (op == `AFU_OP_OR) ? a | b :
                (op == `AFU_OP_XOR) ? a ^ b : s[7:0];
            if ((op >= `AFU_OP_ADD && op <= `AFU_OP_DEC) || op == `AFU_OP_CMP) begin
                o = {((a[7] ^ bb[7]) == sb) && (s[7] != a[7]), n[4], s[8], s[7:0] == 8'h00};
            end else if (op >= `AFU_OP_AND && op <= `AFU_OP_XOR) begin
                o[0] = r == 8'h00;
            end else if (op == `AFU_OP_NOT) begin
                o[0] = a == 8'hff;
            end else if (op == `AFU_OP_NEG || op == `AFU_OP_LOAD) begin
                o[0] = a == 8'h00;
            end else if (op == `AFU_OP_SHR || op == `AFU_OP_SHRC) begin
                o[1] = a[0];
            end else if (op == `AFU_OP_SHL || op == `AFU_OP_SHLC) begin
                o[1] = a[7];
            end else if (op == `AFU_OP_SWAPC) begin
                o[1] = a[b[2:0]];
            end else if (op == `AFU_OP_POPF) begin
                o = b[3:0];
            end
            ref_op = {op >= `AFU_OP_ADD && op <= `AFU_OP_XOR, r, o};
        end
    endfunction
    function [31:0] xs(input [31:0] v);
        begin
            v = v ^ (v << 13);
            v = v ^ (v >> 17);
            xs = v ^ (v << 5);
        end
    endfunction
    task check(input [31:0] seen, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_mismatch);
            if (n_mismatch == 0 && total_checks > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    // Avalon access: hold until waitrequest is sampled low, bounded
    task bus(input wr, input [3:0] ad, input [31:0] wd);
        integer k;
        begin
            @(posedge sys_clk_i);
            avs_address_i <= ad;
            avs_writedata_i <= wd;
            avs_read_i <= !wr;
            avs_write_i <= wr;
            k = 0;
            @(posedge sys_clk_i);
            while (avs_waitrequest_o !== 1'b0 && k < 50) begin
                @(posedge sys_clk_i);
                k = k + 1;
            end
            rd = avs_readdata_o;
            avs_read_i <= 1'b0;
            avs_write_i <= 1'b0;
            if (k == 50) begin
                n_mismatch = n_mismatch + 1;
                test_done;
            end
        end
    endtask
    // One op through the sequencer model, with a bit-range probe alongside
    task run_op(input [4:0] op, input [7:0] a, input [7:0] b, input [7:0] ad);
        begin
            e = ref_op(op, a, b, ef);
            seq_u.issue(op, a, b, ad);
            #1;
            ef = e[3:0];
            check(flags_o, ef);
            if (e[12]) begin
                er = e[11:4];
                check(result_o, er);
            end
            check(bit_ok_o, ad <= 8'h3f);
        end
    endtask
    initial begin
        repeat (10) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        #1;
        check({bit_ok_o, result_o, flags_o}, 13'h0);
        run_op(`AFU_OP_ADD, 8'h7f, 8'h01, 8'h3f);
        run_op(`AFU_OP_ADD, 8'hff, 8'h01, 8'h40);
        run_op(`AFU_OP_SUBC, 8'h00, 8'h00, 8'h00);
        run_op(`AFU_OP_ADDC, 8'hfe, 8'h01, 8'hff);
        run_op(`AFU_OP_SUB, 8'h80, 8'h01, 8'h3e);
        run_op(`AFU_OP_INC, 8'hff, 8'h00, 8'h41);
        run_op(`AFU_OP_DEC, 8'h00, 8'h00, 8'h01);
        run_op(`AFU_OP_CMP, 8'h55, 8'h55, 8'h3f);
        run_op(`AFU_OP_AND, 8'hf0, 8'h0f, 8'h40);
        run_op(`AFU_OP_NOT, 8'hff, 8'h00, 8'h20);
        run_op(`AFU_OP_SWAPC, 8'h08, 8'h03, 8'h80);
        for (i = 0; i < 432; i = i + 1) begin
            rng = xs(rng);
            run_op(i < 32 ? i[4:0] : rng[4:0], rng[12:5], rng[20:13], rng[28:21]);
        end
        run_op(`AFU_OP_ADD, 8'h3c, 8'h4d, 8'h10);
        bus(1'b0, `AFU_OFF_FLAGS, 32'h0);
        check(rd, {28'h0, ef});
        bus(1'b1, `AFU_OFF_FLAGS, 32'hffffffff);
        bus(1'b0, `AFU_OFF_RESULT, 32'h0);
        check(rd, {24'h0, er});
        bus(1'b0, 4'h2, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, `AFU_OFF_OPND, 32'h0000_0190);
        bus(1'b1, `AFU_OFF_CTRL, {27'h0, `AFU_OP_SUB});
        e = ref_op(`AFU_OP_SUB, 8'h90, 8'h01, ef);
        bus(1'b0, `AFU_OFF_FLAGS, 32'h0);
        check(rd, {28'h0, e[3:0]});
        bus(1'b0, `AFU_OFF_RESULT, 32'h0);
        check(rd, {24'h0, e[11:4]});
        test_done;
    end
endmodule // tb
